// >>> eei_regs.vh
`ifndef EEI_REGS_VH
`define EEI_REGS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define EEI_OFS_CTRL     12'h000
`define EEI_OFS_SEL      12'h004
`define EEI_OFS_CTRL_RMW 12'h008
`define EEI_OFS_W        12

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define EEI_C1_FLAG  7
`define EEI_C1_POL_H 6
`define EEI_C1_POL_L 5
`define EEI_C1_EN    4
`define EEI_C0_FLAG  3
`define EEI_C0_POL_H 2
`define EEI_C0_POL_L 1
`define EEI_C0_EN    0
`define EEI_CTRL_RST 8'h00

// ------------------------------------------------------------
// selector register fields
// ------------------------------------------------------------
`define EEI_SEL_DED  6
`define EEI_SEL_EVT  3
`define EEI_SEL_SDI  2
`define EEI_SEL_SCK  1
`define EEI_SEL_TRG  0
`define EEI_SEL_MASK 8'h4f
`define EEI_SEL_RST  8'h40

// ------------------------------------------------------------
// polarity codes
// ------------------------------------------------------------
`define EEI_POL_OFF  2'h0
`define EEI_POL_RISE 2'h1
`define EEI_POL_FALL 2'h2
`define EEI_POL_BOTH 2'h3

// ------------------------------------------------------------
// ahb codes
// ------------------------------------------------------------
`define EEI_HTRANS_NSEQ 2'h2
`define EEI_HSIZE_WORD  3'h2
`define EEI_BYTE_W      8

`endif

// >>> eei_edge_det.v
`timescale 1ns/10ps
`include "eei_regs.vh"

module eei_edge_det
(
   // clock and reset
   input  wire       hclk,
   input  wire       hresetn,
   // synchronised level and polarity code
   input  wire       sig,
   input  wire [1:0] pol,
   // one-cycle detection pulse
   output reg        hit
);

   // ---------------------------------------------------------
   // previous sample
   // ---------------------------------------------------------
   reg prev_q;   // level seen one cycle ago

   // previous sample always tracks, so a mode change never
   // sees a stale level from long ago
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         prev_q <= 1'b0;
      else
         prev_q <= sig;
   end

   // ---------------------------------------------------------
   // edge compare
   // ---------------------------------------------------------
   always @*
   begin
      case (pol)
         `EEI_POL_RISE : hit = sig & ~prev_q;
         `EEI_POL_FALL : hit = ~sig & prev_q;
         `EEI_POL_BOTH : hit = sig ^ prev_q;
         default       : hit = 1'b0;
      endcase
   end

endmodule // eei_edge_det

// >>> eei_top.v
`timescale 1ns/10ps
`include "eei_regs.vh"

module eei_top
(
   // ahb-lite clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // external pins
   input  wire        ch1_interrupt_pin,
   input  wire        dedicated_interrupt_pin,
   input  wire        counter_event_input,
   input  wire        pulse_trigger_input,
   input  wire        serial_clock_input,
   input  wire        serial_data_input,
   // pass-through to own peripherals
   output reg         counter_event_to_timer,
   output reg         pulse_trigger_to_ppg,
   output reg         serial_clock_to_uart,
   output reg         serial_data_to_uart,
   // port data view of the interrupt pins
   output reg  [1:0]  port_pin_data,
   // requests to the interrupt controller
   output reg         ch0_irq,
   output reg         ch1_irq
);

   // ---------------------------------------------------------
   // address decode helper
   // ---------------------------------------------------------
   // true when a byte address lands on a given register word
   function is_reg;
      input [31:0]            addr;
      input [`EEI_OFS_W-1:0]  ofs;
      begin
         is_reg = (addr[`EEI_OFS_W-1:2] == ofs[`EEI_OFS_W-1:2]);
      end
   endfunction

   // ---------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------
   // order: dedicated, ch1, event, trigger, sck, sdi
   localparam NPIN = 6;
   localparam PDED = 0;
   localparam PCH1 = 1;
   localparam PEVT = 2;
   localparam PTRG = 3;
   localparam PSCK = 4;
   localparam PSDI = 5;

   wire [NPIN-1:0] pin_raw;   // raw asynchronous pins
   reg  [NPIN-1:0] meta_q;    // first stage, read by stage two only
   reg  [NPIN-1:0] sync_q;    // second stage, safe to use

   assign pin_raw = {serial_data_input, serial_clock_input,
                     pulse_trigger_input, counter_event_input,
                     ch1_interrupt_pin, dedicated_interrupt_pin};

   // two flops per pin before any logic looks at it
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         meta_q <= {NPIN{1'b0}};
         sync_q <= {NPIN{1'b0}};
      end
      else
      begin
         meta_q <= pin_raw;
         sync_q <= meta_q;
      end
   end

   // ---------------------------------------------------------
   // register state
   // ---------------------------------------------------------
   reg [7:0] ctrl_q;   // edge_interrupt_control
   reg [7:0] ctrl_d;
   reg [7:0] sel_q;    // pin_selector_control
   reg [7:0] sel_d;

   // ---------------------------------------------------------
   // pin selector for channel 0
   // ---------------------------------------------------------
   wire ch0_src;   // combined channel 0 level

   // each pin gated by its select bit, then ored; a cleared
   // select bit forces that pin to zero
   assign ch0_src =
      (sel_q[`EEI_SEL_DED] & sync_q[PDED]) |
      (sel_q[`EEI_SEL_EVT] & sync_q[PEVT]) |
      (sel_q[`EEI_SEL_SDI] & sync_q[PSDI]) |
      (sel_q[`EEI_SEL_SCK] & sync_q[PSCK]) |
      (sel_q[`EEI_SEL_TRG] & sync_q[PTRG]);

   // ---------------------------------------------------------
   // edge detectors
   // ---------------------------------------------------------
   wire hit0;   // channel 0 edge pulse
   wire hit1;   // channel 1 edge pulse

   eei_edge_det u_det0
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .sig     (ch0_src),
      .pol     (ctrl_q[`EEI_C0_POL_H:`EEI_C0_POL_L]),
      .hit     (hit0)
   );

   eei_edge_det u_det1
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .sig     (sync_q[PCH1]),
      .pol     (ctrl_q[`EEI_C1_POL_H:`EEI_C1_POL_L]),
      .hit     (hit1)
   );

   // ---------------------------------------------------------
   // ahb address phase capture
   // ---------------------------------------------------------
   reg        wr_pend_q;   // write data phase pending
   reg [31:0] wr_addr_q;   // address of that write
   wire       ap_valid;    // accepted address phase
   wire       ap_write;
   wire       ap_read;

   assign ap_valid = hsel & hready & (htrans == `EEI_HTRANS_NSEQ);
   assign ap_write = ap_valid & hwrite;
   assign ap_read  = ap_valid & ~hwrite;

   // remember a write so the data phase can apply it
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_q <= ap_write;
         if (ap_write)
            wr_addr_q <= haddr;
      end
   end

   // ---------------------------------------------------------
   // write decode
   // ---------------------------------------------------------
   wire       wr_ctrl;   // control write in data phase
   wire       wr_sel;    // selector write in data phase
   wire [7:0] wbyte;     // low byte of write data

   assign wbyte   = hwdata[`EEI_BYTE_W-1:0];
   // the read-modify-write view also accepts writes, so the
   // write half of such an instruction lands normally
   assign wr_ctrl = wr_pend_q &
                    (is_reg(wr_addr_q, `EEI_OFS_CTRL) |
                     is_reg(wr_addr_q, `EEI_OFS_CTRL_RMW));
   assign wr_sel  = wr_pend_q & is_reg(wr_addr_q, `EEI_OFS_SEL);

   // ---------------------------------------------------------
   // control register next value
   // ---------------------------------------------------------
   // an edge in the same cycle as a clearing write still sets
   // the flag, so no event is ever lost
   always @*
   begin
      ctrl_d = ctrl_q;
      if (wr_ctrl)
      begin
         // polarity and enable bits store as written
         ctrl_d[`EEI_C1_POL_H:`EEI_C1_POL_L] =
            wbyte[`EEI_C1_POL_H:`EEI_C1_POL_L];
         ctrl_d[`EEI_C1_EN] = wbyte[`EEI_C1_EN];
         ctrl_d[`EEI_C0_POL_H:`EEI_C0_POL_L] =
            wbyte[`EEI_C0_POL_H:`EEI_C0_POL_L];
         ctrl_d[`EEI_C0_EN] = wbyte[`EEI_C0_EN];
         // flags: zero clears, one leaves alone
         ctrl_d[`EEI_C1_FLAG] =
            ctrl_q[`EEI_C1_FLAG] & wbyte[`EEI_C1_FLAG];
         ctrl_d[`EEI_C0_FLAG] =
            ctrl_q[`EEI_C0_FLAG] & wbyte[`EEI_C0_FLAG];
      end
      if (hit1)
         ctrl_d[`EEI_C1_FLAG] = 1'b1;
      if (hit0)
         ctrl_d[`EEI_C0_FLAG] = 1'b1;
   end

   // ---------------------------------------------------------
   // selector register next value
   // ---------------------------------------------------------
   always @*
   begin
      sel_d = sel_q;
      if (wr_sel)
         sel_d = wbyte & `EEI_SEL_MASK;
   end

   // ---------------------------------------------------------
   // register flops
   // ---------------------------------------------------------
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_q <= `EEI_CTRL_RST;
         sel_q  <= `EEI_SEL_RST;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         sel_q  <= sel_d;
      end
   end

   // ---------------------------------------------------------
   // interrupt requests
   // ---------------------------------------------------------
   // built from next values so a request follows its flag in
   // the same cycle; a cleared enable blocks it at once
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ch1_irq <= 1'b0;
         ch0_irq <= 1'b0;
      end
      else
      begin
         ch1_irq <= ctrl_d[`EEI_C1_FLAG] & ctrl_d[`EEI_C1_EN];
         ch0_irq <= ctrl_d[`EEI_C0_FLAG] & ctrl_d[`EEI_C0_EN];
      end
   end

   // ---------------------------------------------------------
   // read data
   // ---------------------------------------------------------
   reg [7:0] rd_byte;   // selected register value

   // next values are used so a read right after a write sees
   // the written data
   always @*
   begin
      rd_byte = 8'h00;
      if (is_reg(haddr, `EEI_OFS_CTRL))
         rd_byte = ctrl_d;
      else if (is_reg(haddr, `EEI_OFS_SEL))
         rd_byte = sel_d & `EEI_SEL_MASK;
      else if (is_reg(haddr, `EEI_OFS_CTRL_RMW))
      begin
         // the read half of read-modify-write sees both flags
         // as one, so its write-back cannot clear them
         rd_byte = ctrl_d;
         rd_byte[`EEI_C1_FLAG] = 1'b1;
         rd_byte[`EEI_C0_FLAG] = 1'b1;
      end
   end

   // data is registered at the address-phase edge; unmapped
   // addresses read zero
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (ap_read)
         hrdata <= {{(32-`EEI_BYTE_W){1'b0}}, rd_byte};
      else
         hrdata <= 32'h0000_0000;
   end

   // ---------------------------------------------------------
   // bus response
   // ---------------------------------------------------------
   // zero wait states, always okay
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // ---------------------------------------------------------
   // pin pass-through and port data view
   // ---------------------------------------------------------
   // shared pins keep feeding their peripherals whatever the
   // selector holds; the dedicated pin has no peripheral
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         counter_event_to_timer <= 1'b0;
         pulse_trigger_to_ppg   <= 1'b0;
         serial_clock_to_uart   <= 1'b0;
         serial_data_to_uart    <= 1'b0;
         port_pin_data          <= 2'h0;
      end
      else
      begin
         counter_event_to_timer <= sync_q[PEVT];
         pulse_trigger_to_ppg   <= sync_q[PTRG];
         serial_clock_to_uart   <= sync_q[PSCK];
         serial_data_to_uart    <= sync_q[PSDI];
         // levels shown regardless of any enable bit
         port_pin_data <= {sync_q[PCH1], sync_q[PDED]};
      end
   end

endmodule // eei_top

// >>> eei_top_monitor.sv
`timescale 1ns/10ps
module eei_top_monitor
(
   // bus side
   input wire        hclk,
   input wire        hresetn,
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire        hready,
   input wire [31:0] hrdata,
   input wire        hreadyout,
   input wire        hresp,
   // pins and their views
   input wire        counter_event_input,
   input wire        counter_event_to_timer,
   input wire        ch1_interrupt_pin,
   input wire [1:0]  port_pin_data,
   // requests
   input wire        ch0_irq,
   input wire        ch1_irq
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ----------------------------------------------------
   // data phase tracking
   // ----------------------------------------------------
   wire       take_w = hsel & hready & (htrans == 2'h2);
   reg        rd_q;   // read in data phase
   reg        wr_q;   // write in data phase
   reg [11:0] ofs_q;  // offset of that phase
   // one flop stage mirrors the slave's data phase
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_q  <= 1'b0;
         wr_q  <= 1'b0;
         ofs_q <= 12'h000;
      end
      else
      begin
         rd_q  <= take_w & ~hwrite;
         wr_q  <= take_w & hwrite;
         ofs_q <= haddr[11:0];
      end
   end
   // ----------------------------------------------------
   // properties
   // ----------------------------------------------------
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("slave not ready or not okay");
   a_rdata_idle: assert property (!rd_q |-> hrdata == 32'h0)
      else $error("read data outside data phase");
   a_sel_reserved: assert property (
      rd_q && ofs_q == 12'h004 |-> !hrdata[7] && hrdata[5:4] == 2'h0)
      else $error("selector unused bits not zero");
   a_rmw_flags: assert property (
      rd_q && ofs_q == 12'h008 |-> hrdata[7] && hrdata[3])
      else $error("rmw view flags not one");
   a_irq1_flag: assert property (
      rd_q && ofs_q == 12'h000 |-> ch1_irq == (hrdata[7] & hrdata[4]))
      else $error("ch1 request differs from flag and enable");
   a_irq0_flag: assert property (
      rd_q && ofs_q == 12'h000 |-> ch0_irq == (hrdata[3] & hrdata[0]))
      else $error("ch0 request differs from flag and enable");
   a_irq_clear_cause: assert property (
      $fell(ch0_irq) || $fell(ch1_irq) |-> $past(wr_q))
      else $error("request dropped without a write");
   a_pass_event: assert property (
      $rose(counter_event_input) |-> ##[1:4] counter_event_to_timer)
      else $error("event input not passed to timer");
   a_port_view: assert property (
      $rose(ch1_interrupt_pin) |-> ##[1:4] port_pin_data[1])
      else $error("ch1 pin level not in port data");
endmodule // eei_top_monitor

bind eei_top eei_top_monitor i_mon (.hclk, .hresetn, .hsel, .haddr,
   .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
   .counter_event_input, .counter_event_to_timer, .ch1_interrupt_pin,
   .port_pin_data, .ch0_irq, .ch1_irq);

// >>> eei_pin_src.sv
`timescale 1ns/10ps
module eei_pin_src
(
   // commanded levels: bit7 ch1, others as selector bits
   input wire [7:0] cmd,
   // pins toward the block
   output reg [7:0] pins
);
   // sources are unrelated to hclk, so land well off the edge;
   // the pins are only ever inputs, nothing drives them back
   initial pins = 8'h00;
   always @(cmd)
      pins <= #30 cmd;
endmodule // eei_pin_src

// >>> eei_top_tb.sv
`timescale 1ns/10ps
`include "eei_regs.vh"
module eei_top_tb;
   // ----------------------------------------------------
   // signals
   // ----------------------------------------------------
   reg         hclk;
   reg         hresetn;
   reg         hsel;
   reg  [31:0] haddr;
   reg  [1:0]  htrans;
   reg         hwrite;
   reg  [2:0]  hsize;
   reg  [31:0] hwdata;
   wire [31:0] hrdata;
   wire        hreadyout;
   wire        hresp;
   reg  [7:0]  pins_q;   // commanded pin levels
   wire [7:0]  pin_w;    // levels seen at the pins
   wire [3:0]  pass_w;   // event, data, clock, trigger views
   wire [1:0]  ppd_w;
   wire        irq0;
   wire        irq1;
   integer     failures;
   integer     num_checks;
   integer     b;
   integer     p;
   reg  [31:0] rd;
   // ----------------------------------------------------
   // block, far side and clock
   // ----------------------------------------------------
   eei_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp),
      .ch1_interrupt_pin(pin_w[7]), .dedicated_interrupt_pin(pin_w[6]),
      .counter_event_input(pin_w[3]), .serial_data_input(pin_w[2]),
      .serial_clock_input(pin_w[1]), .pulse_trigger_input(pin_w[0]),
      .counter_event_to_timer(pass_w[3]), .serial_data_to_uart(pass_w[2]),
      .serial_clock_to_uart(pass_w[1]), .pulse_trigger_to_ppg(pass_w[0]),
      .port_pin_data(ppd_w), .ch0_irq(irq0), .ch1_irq(irq1));
   eei_pin_src i_src (.cmd(pins_q), .pins(pin_w));
   initial
   begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   // ----------------------------------------------------
   // tasks
   // ----------------------------------------------------
   task conclude;
   begin
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   end
   endtask
   task chk_reg(input [31:0] g, input [31:0] e);
   begin
      num_checks = num_checks + 1;
      if (g !== e)
      begin
         failures = failures + 1;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   end
   endtask
   task chk_bit(input g, input e);
   begin
      num_checks = num_checks + 1;
      if (g !== e)
      begin
         failures = failures + 1;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   end
   endtask
   // one single transfer; waits on ready, never on a fixed count
   task xfer(input [31:0] a, input w, input [31:0] wd);
   begin
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      hsize  <= `EEI_HSIZE_WORD;
      htrans <= `EEI_HTRANS_NSEQ;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   end
   endtask
   // one idle edge after the data phase, so outputs updated by
   // the write have settled before anyone looks at them
   task wr(input [31:0] a, input [7:0] d);
   begin
      xfer(a, 1'b1, {24'h0, d});
      @(posedge hclk);
   end
   endtask
   task rd_chk(input [31:0] a, input [7:0] e);
   begin
      xfer(a, 1'b0, 32'h0);
      chk_reg(rd, {24'h0, e});
   end
   endtask
   // sync plus detect needs three edges; six leaves margin
   task drive(input [7:0] v);
   begin
      pins_q <= v;
      repeat (6) @(posedge hclk);
   end
   endtask
   // ----------------------------------------------------
   // watchdog, far above the few hundred cycles needed
   // ----------------------------------------------------
   initial
   begin
      repeat (20000) @(posedge hclk);
      failures = failures + 1;
      conclude;
   end
   // ----------------------------------------------------
   // main sequence
   // ----------------------------------------------------
   initial
   begin
      failures = 0;
      num_checks = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      pins_q = 8'h00;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk(`EEI_OFS_CTRL, `EEI_CTRL_RST);
      rd_chk(`EEI_OFS_SEL, `EEI_SEL_RST);
      chk_bit(irq0 | irq1, 1'b0);
      wr(`EEI_OFS_SEL, 8'hff);
      rd_chk(`EEI_OFS_SEL, 8'h4f);
      wr(32'h0000_000c, 8'hff);
      rd_chk(32'h0000_000c, 8'h00);
      // ch1 through every polarity code
      for (p = 0; p < 4; p = p + 1)
      begin
         wr(`EEI_OFS_CTRL, 8'h00);
         wr(`EEI_OFS_CTRL, {1'b0, p[1:0], 1'b1, 4'h0});
         drive(8'h80);
         chk_bit(irq1, p[0]);
         chk_bit(ppd_w[1], 1'b1);
         drive(8'h00);
         rd_chk(`EEI_OFS_CTRL, {p != 0, p[1:0], 1'b1, 4'h0});
      end
      wr(`EEI_OFS_CTRL, 8'hf0);
      chk_bit(irq1, 1'b1);
      wr(`EEI_OFS_CTRL, 8'h70);
      chk_bit(irq1, 1'b0);
      // ch0 from each selectable pin, other pin deselected
      for (b = 0; b < 7; b = b + 1)
         if (b < 4 || b == 6)
         begin
            wr(`EEI_OFS_SEL, 8'h01 << b);
            wr(`EEI_OFS_CTRL, 8'h03);
            drive(b == 6 ? 8'h08 : 8'h40);
            chk_bit(irq0, 1'b0);
            drive((8'h01 << b) | (b == 6 ? 8'h08 : 8'h40));
            chk_bit(irq0, 1'b1);
            chk_reg({28'h0, pass_w}, {28'h0, pins_q[3:0]});
            chk_bit(ppd_w[0], pins_q[6]);
            drive(8'h00);
         end
      wr(`EEI_OFS_CTRL, 8'h0a);
      chk_bit(irq0, 1'b0);
      rd_chk(`EEI_OFS_CTRL, 8'h0a);
      rd_chk(`EEI_OFS_CTRL_RMW, 8'h8a);
      wr(`EEI_OFS_CTRL_RMW, 8'h02);
      rd_chk(`EEI_OFS_CTRL, 8'h02);
      // two selected pins are ored: a second high pin is no edge,
      // and the ored level stays high until both are low
      wr(`EEI_OFS_SEL, 8'h48);
      wr(`EEI_OFS_CTRL, 8'h03);
      drive(8'h08);
      chk_bit(irq0, 1'b1);
      wr(`EEI_OFS_CTRL, 8'h03);
      drive(8'h48);
      chk_bit(irq0, 1'b0);
      drive(8'h40);
      chk_bit(irq0, 1'b0);
      drive(8'h00);
      wr(`EEI_OFS_CTRL, 8'h01);
      drive(8'h40);
      drive(8'h00);
      rd_chk(`EEI_OFS_CTRL, 8'h01);
      conclude;
   end
endmodule // eei_top_tb
